// file: hw/spinvm_pkg.sv
package spinvm_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 11;
    localparam int          DATA_W      = 8;
    localparam int          DEPTH       = 2048;
    localparam logic [10:0] ADDR_LAST   = 11'h7FF;
    localparam logic [10:0] ADDR_FIRST  = 11'h000;
    localparam logic [10:0] GUARD_QTR   = 11'h600;
    localparam logic [10:0] GUARD_HALF  = 11'h400;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ARM      = 8'h06;
    localparam logic [7:0] OP_DISARM   = 8'h04;
    localparam logic [7:0] OP_STAT_RD  = 8'h05;
    localparam logic [7:0] OP_STAT_WR  = 8'h01;
    localparam logic [7:0] OP_MEM_RD   = 8'h03;
    localparam logic [7:0] OP_MEM_WR   = 8'h02;

    // ------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------
    localparam int         ST_LOCK_BIT = 7;
    localparam int         ST_BGHI_BIT = 3;
    localparam int         ST_BGLO_BIT = 2;
    localparam int         ST_WPL_BIT  = 1;
    localparam logic       RST_LOCK    = 1'b0;
    localparam logic [1:0] RST_GUARD   = 2'h0;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [1:0] GUARD_NONE  = 2'h0;
    localparam logic [1:0] GUARD_UPQ   = 2'h1;
    localparam logic [1:0] GUARD_UPH   = 2'h2;

    // Transaction phases
    typedef enum logic [7:0] {
        ST_OP    = 8'h01,
        ST_ADH   = 8'h02,
        ST_ADL   = 8'h04,
        ST_WDATA = 8'h08,
        ST_RDATA = 8'h10,
        ST_SRD   = 8'h20,
        ST_SWR   = 8'h40,
        ST_IGN   = 8'h80
    } spinvm_state_t;

endpackage : spinvm_pkg

// file: hw/spinvm_sync.sv
`timescale 1ns/1ps
module spinvm_sync #(
    parameter int          W     = 1,
    parameter logic [31:0] RSTV  = 32'h0
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // ------------------------------------------------------------
    // Two-stage synchroniser, first stage read only by the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= RSTV[W-1:0];
            q    <= RSTV[W-1:0];
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : spinvm_sync

// file: hw/spinvm_buf2.sv
`timescale 1ns/1ps
module spinvm_buf2 #(
    parameter int W = 19
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [W-1:0] slot [2];
    logic         rd_ptr;
    logic         wr_ptr;
    logic [1:0]   count;
    logic         push;
    logic         pop;

    // Honest full and empty
    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ------------------------------------------------------------
    // Storage, no reset needed on data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : spinvm_buf2

// file: hw/spinvm_core.sv
`timescale 1ns/1ps
module spinvm_core (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Serial pins
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    output logic      so,
    output logic      so_oe,
    input  wire logic hold_n,
    input  wire logic status_guard_n,
    // Array write port stall
    input  wire logic mem_stall,
    // State observation
    output logic      status_lock_enable,
    output logic      block_guard_hi,
    output logic      block_guard_lo,
    output logic      write_permit_latch,
    output logic      paused,
    output logic      commit_stall
);
    localparam int BW = spinvm_pkg::ADDR_W + spinvm_pkg::DATA_W;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic hold_s;
    logic wp_s;

    // Reset image matches idle pins (select high, clock low, pause high, guard high)
    spinvm_sync #(.W(5), .RSTV(32'h13)) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       ({cs_n, sck, si, hold_n, status_guard_n}),
        .q       ({cs_s, sck_s, si_s, hold_s, wp_s})
    );

    // ------------------------------------------------------------
    // Edge finding on synchronised levels
    // ------------------------------------------------------------
    logic sck_q;
    logic hold_q;
    logic cs_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sck_q  <= 1'b0;
            hold_q <= 1'b1;
            cs_q   <= 1'b1;
        end else begin
            sck_q  <= sck_s;
            hold_q <= hold_s;
            cs_q   <= cs_s;
        end
    end

    // Clock edges only count while selected and not paused; the deselect edge is not gated
    assign sck_rise = sck_s && !sck_q && !cs_s && !paused;
    assign sck_fall = !sck_s && sck_q && !cs_s && !paused;
    assign cs_rise  = cs_s && !cs_q;

    // ------------------------------------------------------------
    // Pause control
    // ------------------------------------------------------------
    // Pin moves with clock high are ignored so a stray edge never freezes a byte
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            paused <= 1'b0;
        end else if (!sck_s && hold_q && !hold_s) begin
            paused <= 1'b1;
        end else if (!sck_s && !hold_q && hold_s) begin
            paused <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [7:0] next_rx;
    logic       byte_done;

    assign next_rx   = {rx_sh[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt == spinvm_pkg::BIT_LAST);

    // Bit count restarts on every select
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_sh   <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (cs_s) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            rx_sh   <= next_rx;
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    spinvm_pkg::spinvm_state_t state;
    logic [10:0] addr;
    logic [2:0]  addr_hi;
    logic        wrote;
    logic        op_is_rd;
    logic        tx_load;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= spinvm_pkg::ST_OP;
        end else if (cs_s) begin
            state <= spinvm_pkg::ST_OP;
        end else if (byte_done) begin
            case (state)
                spinvm_pkg::ST_OP: begin
                    if (next_rx == spinvm_pkg::OP_MEM_RD || next_rx == spinvm_pkg::OP_MEM_WR) begin
                        state <= spinvm_pkg::ST_ADH;
                    end else if (next_rx == spinvm_pkg::OP_STAT_RD) begin
                        state <= spinvm_pkg::ST_SRD;
                    end else if (next_rx == spinvm_pkg::OP_STAT_WR) begin
                        state <= spinvm_pkg::ST_SWR;
                    end else begin
                        state <= spinvm_pkg::ST_IGN;
                    end
                end
                spinvm_pkg::ST_ADH: begin
                    state <= spinvm_pkg::ST_ADL;
                end
                spinvm_pkg::ST_ADL: begin
                    state <= op_is_rd ? spinvm_pkg::ST_RDATA : spinvm_pkg::ST_WDATA;
                end
                spinvm_pkg::ST_SWR: begin
                    state <= spinvm_pkg::ST_IGN;
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Remember which memory command owns the address phase
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            op_is_rd <= 1'b0;
        end else if (byte_done && state == spinvm_pkg::ST_OP) begin
            op_is_rd <= (next_rx == spinvm_pkg::OP_MEM_RD);
        end
    end

    // ------------------------------------------------------------
    // Address counter
    // ------------------------------------------------------------
    logic addr_step;
    assign addr_step = (byte_done && state == spinvm_pkg::ST_WDATA)
                     || (tx_load && state == spinvm_pkg::ST_RDATA);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr    <= spinvm_pkg::ADDR_FIRST;
            addr_hi <= 3'h0;
        end else if (byte_done && state == spinvm_pkg::ST_ADH) begin
            addr_hi <= next_rx[2:0];
        end else if (byte_done && state == spinvm_pkg::ST_ADL) begin
            addr    <= {addr_hi, next_rx};
        end else if (addr_step) begin
            addr    <= addr + 11'h001;
        end
    end

    // ------------------------------------------------------------
    // Status bits and write permit latch
    // ------------------------------------------------------------
    logic stat_ok;
    assign stat_ok = write_permit_latch && !(status_lock_enable && !wp_s);

    // Guard bits are volatile here; a reset returns them to open
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_lock_enable <= spinvm_pkg::RST_LOCK;
            block_guard_hi     <= spinvm_pkg::RST_GUARD[1];
            block_guard_lo     <= spinvm_pkg::RST_GUARD[0];
        end else if (byte_done && state == spinvm_pkg::ST_SWR && stat_ok) begin
            status_lock_enable <= next_rx[spinvm_pkg::ST_LOCK_BIT];
            block_guard_hi     <= next_rx[spinvm_pkg::ST_BGHI_BIT];
            block_guard_lo     <= next_rx[spinvm_pkg::ST_BGLO_BIT];
        end
    end

    // Notes that a write transaction ran, for clearing at deselect
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrote <= 1'b0;
        end else if (cs_rise) begin
            wrote <= 1'b0;
        end else if (byte_done && (state == spinvm_pkg::ST_SWR
                     || state == spinvm_pkg::ST_WDATA)) begin
            wrote <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            write_permit_latch <= 1'b0;
        end else if (cs_rise && wrote) begin
            write_permit_latch <= 1'b0;
        end else if (byte_done && state == spinvm_pkg::ST_OP) begin
            if (next_rx == spinvm_pkg::OP_ARM) begin
                write_permit_latch <= 1'b1;
            end else if (next_rx == spinvm_pkg::OP_DISARM) begin
                write_permit_latch <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Block guard decode
    // ------------------------------------------------------------
    function automatic logic guarded(input logic [1:0] g, input logic [10:0] a);
        if (g == spinvm_pkg::GUARD_NONE) begin
            return 1'b0;
        end else if (g == spinvm_pkg::GUARD_UPQ) begin
            return a >= spinvm_pkg::GUARD_QTR;
        end else if (g == spinvm_pkg::GUARD_UPH) begin
            return a >= spinvm_pkg::GUARD_HALF;
        end else begin
            return 1'b1;
        end
    endfunction : guarded

    // ------------------------------------------------------------
    // Commit path: pending slot then two-entry buffer
    // ------------------------------------------------------------
    logic          pend_v;
    logic [BW-1:0] pend_d;
    logic          buf_ready;
    logic          push;
    logic          take;
    logic          drain_v;
    logic [BW-1:0] drain_d;

    // Only permitted, unguarded bytes are queued
    assign take = byte_done && state == spinvm_pkg::ST_WDATA && write_permit_latch
                && !guarded({block_guard_hi, block_guard_lo}, addr);
    assign push = pend_v && buf_ready;
    assign commit_stall = pend_v && !buf_ready;

    // A full buffer holds the byte here; at link rates it drains long before the next
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_v <= 1'b0;
            pend_d <= '0;
        end else if (take) begin
            pend_v <= 1'b1;
            pend_d <= {addr, next_rx};
        end else if (push) begin
            pend_v <= 1'b0;
        end
    end

    spinvm_buf2 #(.W(BW)) u_buf (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (pend_v),
        .in_ready  (buf_ready),
        .in_data   (pend_d),
        .out_valid (drain_v),
        .out_ready (!mem_stall),
        .out_data  (drain_d)
    );

    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    logic [7:0] mem [spinvm_pkg::DEPTH];

    always_ff @(posedge clk_sys) begin
        if (drain_v && !mem_stall) begin
            mem[drain_d[BW-1:8]] <= drain_d[7:0];
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic [2:0] tx_cnt;
    logic [6:0] tx_sh;
    logic       tx_state;
    logic [7:0] stat_byte;
    logic [7:0] tx_byte;

    assign stat_byte = {status_lock_enable, 3'h0, block_guard_hi,
                        block_guard_lo, write_permit_latch, 1'b0};
    assign tx_state  = (state == spinvm_pkg::ST_RDATA) || (state == spinvm_pkg::ST_SRD);
    assign tx_load   = sck_fall && tx_state && (tx_cnt == 3'h0);
    assign tx_byte   = (state == spinvm_pkg::ST_SRD) ? stat_byte : mem[addr];

    // Bit 7 goes out on the first falling edge of each byte
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            so     <= 1'b0;
            tx_sh  <= 7'h00;
            tx_cnt <= 3'h0;
        end else if (cs_s) begin
            tx_cnt <= 3'h0;
        end else if (sck_fall && tx_state) begin
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == 3'h0) begin
                so    <= tx_byte[7];
                tx_sh <= tx_byte[6:0];
            end else begin
                so    <= tx_sh[6];
                tx_sh <= {tx_sh[5:0], 1'b0};
            end
        end
    end

    // Output released when deselected or paused
    assign so_oe = !cs_s && !paused && tx_state;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_arm_byte;
        byte_done && state == spinvm_pkg::ST_OP && next_rx == spinvm_pkg::OP_ARM;
    endsequence
    sequence s_locked_swr;
        byte_done && state == spinvm_pkg::ST_SWR && status_lock_enable && !wp_s;
    endsequence

    AST_ARM_SETS: assert property (s_arm_byte |=> write_permit_latch)
        else $error("arm command did not set latch");
    AST_SR_LOCKED: assert property (s_locked_swr |=> $stable(block_guard_hi)
        && $stable(block_guard_lo) && $stable(status_lock_enable))
        else $error("locked status write took effect");
    AST_SR_NOLOCK: assert property (byte_done && state == spinvm_pkg::ST_SWR
        && write_permit_latch && !status_lock_enable
        |=> block_guard_lo == $past(next_rx[2]))
        else $error("unlocked status write ignored");
    AST_ADDR_WRAP: assert property (addr_step && addr == spinvm_pkg::ADDR_LAST
        |=> addr == spinvm_pkg::ADDR_FIRST)
        else $error("address did not wrap");
    AST_PAUSE_HIZ: assert property (paused |-> !so_oe)
        else $error("output driven while paused");
    AST_CS_END: assert property ($rose(cs_s) |=> state == spinvm_pkg::ST_OP
        && !so_oe)
        else $error("deselect did not end transaction");
    AST_NO_GUARD_WR: assert property (take |-> write_permit_latch
        && !guarded({block_guard_hi, block_guard_lo}, addr))
        else $error("guarded byte queued");
    AST_LATCH_CLR: assert property (cs_rise && wrote |=> !write_permit_latch)
        else $error("latch survived write");
    AST_COMMIT: assert property (take && !mem_stall && buf_ready
        |-> ##[1:3] drain_v)
        else $error("byte not committed");
    AST_PAUSE_HOLD: assert property (paused && sck_s && !sck_q |=> $stable(bit_cnt))
        else $error("edge counted while paused");
endmodule : spinvm_core

// file: test/spinvm_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host model
// ------------------------------------------------------------
module spinvm_host (
    // Pins towards the device
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    // Pin from the device
    input  wire logic so
);
    // Clock stands low between frames
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
    end
    // Frame open, clock low
    task start();
        cs_n = 1'b0;
        #48;
    endtask : start
    // Frame close; released line drops its last bit
    task stop();
        cs_n = 1'b1;
        si   = ~si;
        #100;
    endtask : stop
    // One byte, slow enough for the 30 ns edge spacing
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #48 sck = 1'b1;
            rx[i] = so;
            #48 sck = 1'b0;
        end
        si = ~si;
    endtask : xfer
    // Pause pin moves with clock low; clock keeps running inside
    task hold(input logic lvl);
        hold_n = lvl;
        #60;
        if (!lvl) begin
            repeat (2) begin
                si = ~si;
                #48 sck = 1'b1;
                #48 sck = 1'b0;
            end
        end
    endtask : hold
endmodule : spinvm_host

// file: test/spinvm_core_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench for the access and protection core
// ------------------------------------------------------------
module spinvm_core_bench;
    // Pins and observed state
    logic        clk_sys, rstn, cs_n, sck, si, so, so_oe, hold_n;
    logic        status_guard_n, mem_stall, status_lock_enable, block_guard_hi;
    logic        block_guard_lo, write_permit_latch, paused, commit_stall;
    // Expected state
    logic [7:0]  exp_mem [0:2047];
    logic [10:0] ga [4] = '{11'h3FF, 11'h400, 11'h5FF, 11'h600};
    logic [1:0]  g;
    logic        lock;
    logic [7:0]  rx;
    int          n_errors, n_compared;

    spinvm_core dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
        .so(so), .so_oe(so_oe), .hold_n(hold_n), .status_guard_n(status_guard_n),
        .mem_stall(mem_stall), .status_lock_enable(status_lock_enable),
        .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo),
        .write_permit_latch(write_permit_latch), .paused(paused),
        .commit_stall(commit_stall));
    spinvm_host host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so));

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task final_report();
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task cmd(input logic [7:0] op);
        host.start();
        host.xfer(op, rx);
        host.stop();
    endtask : cmd

    // Guard code decides which addresses an armed write reaches
    function automatic logic ok(input logic [10:0] a);
        return g == 2'h0 || (g == 2'h1 && a < 11'h600) || (g == 2'h2 && a < 11'h400);
    endfunction : ok

    // Write n bytes counting up from d; junk in the upper address bits
    task wr(input logic [10:0] a, input logic [7:0] d, input int n, input logic arm);
        if (arm) cmd(spinvm_pkg::OP_ARM);
        host.start();
        host.xfer(spinvm_pkg::OP_MEM_WR, rx);
        host.xfer({5'h15, a[10:8]}, rx);
        host.xfer(a[7:0], rx);
        for (int i = 0; i < n; i++) begin
            host.xfer(d + 8'(i), rx);
            if (arm && ok(a)) exp_mem[a] = d + 8'(i);
            a = a + 11'h1;
        end
        host.stop();
        chk("latch", {7'h0, write_permit_latch}, 8'h0);
    endtask : wr

    // Read n bytes; si carries junk; optional pause after first byte
    task rd(input logic [10:0] a, input int n, input logic p);
        host.start();
        host.xfer(spinvm_pkg::OP_MEM_RD, rx);
        host.xfer({5'h0A, a[10:8]}, rx);
        host.xfer(a[7:0], rx);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h5A ^ 8'(i), rx);
            chk("rdata", rx, exp_mem[a]);
            if (p && i == 0) begin
                host.hold(1'b0);
                chk("paused", {6'h0, paused, so_oe}, 8'h2);
                host.hold(1'b1);
                chk("resumed", {6'h0, paused, so_oe}, 8'h1);
            end
            a = a + 11'h1;
        end
        host.stop();
        chk("so_oe", {7'h0, so_oe}, 8'h0);
    endtask : rd

    // Status write after arming, then read back
    task sw(input logic [7:0] v);
        cmd(spinvm_pkg::OP_ARM);
        host.start();
        host.xfer(spinvm_pkg::OP_STAT_WR, rx);
        host.xfer(v, rx);
        host.stop();
        if (!(lock && !status_guard_n)) begin
            lock = v[7];
            g    = v[3:2];
        end
        chk("stat", {status_lock_enable, 4'h0, block_guard_hi, block_guard_lo,
            write_permit_latch}, {lock, 4'h0, g, 1'b0});
        host.start();
        host.xfer(spinvm_pkg::OP_STAT_RD, rx);
        host.xfer(8'h00, rx);
        host.stop();
        chk("stat_rd", rx, {lock, 3'h0, g, 2'h0});
    endtask : sw

    // Main sequence
    initial begin
        rstn           = 1'b0;
        status_guard_n = 1'b1;
        mem_stall      = 1'b0;
        lock           = 1'b0;
        g              = 2'h0;
        n_errors       = 0;
        n_compared     = 0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("reset", {2'h0, so_oe, status_lock_enable, block_guard_hi, block_guard_lo,
            write_permit_latch, commit_stall}, 8'h0);
        cmd(spinvm_pkg::OP_ARM);
        chk("arm", {7'h0, write_permit_latch}, 8'h1);
        cmd(spinvm_pkg::OP_DISARM);
        chk("disarm", {7'h0, write_permit_latch}, 8'h0);
        wr(11'h010, 8'h3C, 1, 1'b1);
        wr(11'h010, 8'hA5, 1, 1'b0);
        rd(11'h010, 1, 1'b0);
        wr(11'h7FF, 8'h81, 3, 1'b1);
        rd(11'h7FF, 3, 1'b1);
        for (int c = 0; c < 4; c++) begin
            sw({4'h0, 2'(c), 2'h0});
            foreach (ga[k]) begin
                wr(ga[k], 8'h40 + 8'(4 * c + k), 1, 1'b1);
                rd(ga[k], 1, 1'b0);
            end
        end
        sw(8'h8C);
        @(posedge clk_sys) status_guard_n <= 1'b0;
        sw(8'h80);
        @(posedge clk_sys) status_guard_n <= 1'b1;
        sw(8'h80);
        @(posedge clk_sys) status_guard_n <= 1'b0;
        wr(11'h020, 8'h77, 1, 1'b1);
        rd(11'h020, 1, 1'b0);
        @(posedge clk_sys) status_guard_n <= 1'b1;
        sw(8'h00);
        @(posedge clk_sys) status_guard_n <= 1'b0;
        sw(8'h04);
        @(posedge clk_sys) status_guard_n <= 1'b1;
        sw(8'h00);
        // Stalled array port: bytes must wait, not vanish
        @(posedge clk_sys) mem_stall <= 1'b1;
        wr(11'h100, 8'hE0, 3, 1'b1);
        chk("stall", {7'h0, commit_stall}, 8'h1);
        @(posedge clk_sys) mem_stall <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("drain", {7'h0, commit_stall}, 8'h0);
        rd(11'h100, 3, 1'b0);
        final_report();
    end

    // Watchdog well beyond the expected run time
    initial begin
        #400000;
        n_errors++;
        final_report();
    end
endmodule : spinvm_core_bench
